/* File: wdt_watchdog.sv */
`timescale 1ns/1ns

module wdt_watchdog
   import wdt_pkg::*;
#(
   parameter int unsigned POR_CYCLES = WDT_POR_CYCLES,
   parameter int unsigned RST_PULSE_CYCLES = WDT_RST_PULSE_CYCLES
) (
   // Oscillator output clock and power-on reset.
   input wire logic clock,
   input wire logic rst,
   // Register port.
   input wire wdt_bus_req_t bus_req,
   output logic [WDT_DATA_W-1:0] bus_rdata,
   // Low reset-vector byte presented by the memory behind the service location.
   input wire logic [WDT_DATA_W-1:0] reset_vector_low,
   // System controls on this clock.
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic stop_mode,
   input wire logic internal_reset,
   input wire logic reset_vector_fetch,
   // High-voltage detectors on the reset and interrupt pins, asynchronous.
   input wire logic test_high_voltage_rst_pin,
   input wire logic test_high_voltage_interrupt_pin,
   // Reset request and open-drain reset pin drive.
   output logic watchdog_reset_req,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   // Event line to the system unit.
   output logic event_irq
);

   // Refuse geometries the counting logic cannot serve.
   if (POR_CYCLES < 1 || RST_PULSE_CYCLES < 1) begin : g_chk
      $error("wdt_watchdog: cycle counts must be at least 1.");
   end

   localparam int unsigned POR_W = $clog2(POR_CYCLES + 1);
   localparam int unsigned PULSE_W = $clog2(RST_PULSE_CYCLES + 1);
   localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(RST_PULSE_CYCLES);
   localparam logic [PULSE_W-1:0] PULSE_ONE = PULSE_W'(1);
   localparam logic [WDT_COUNT_W-1:0] COUNT_MAX = '1;

   // Synchronised high-voltage detectors.
   logic [1:0] hv_sync;
   logic hv_rst_pin; // High voltage seen on the reset pin.
   logic hv_irq_pin; // High voltage seen on the interrupt pin.

   // Register state.
   logic [7:0] config_q; // Configuration register.
   logic [7:0] cause_q; // Reset cause register.
   logic [WDT_EV_W-1:0] status_q; // Sticky event bits.
   logic [WDT_EV_W-1:0] mask_q; // Event enables.
   logic [WDT_DATA_W-1:0] rdata_q; // Registered read data.

   // Counting state.
   logic [WDT_PRESC_W-1:0] presc_q; // Prescaler stages 1 to 12.
   logic [WDT_COUNT_W-1:0] count_q; // Watchdog counter.
   logic [PULSE_W-1:0] pulse_q; // Remaining reset pin low cycles.
   logic [POR_W-1:0] por_cnt_q; // Cycles since power up.
   wdt_por_state_t por_state_q; // Power-on sequencer.

   // Decoded controls.
   wdt_cfg_t cfg;
   logic wd_disabled; // Counting held off.
   logic service_wr; // Service location written.
   logic por_clear; // One-cycle prescaler clear after power up.
   logic presc_clear_all; // Clears every prescaler stage.
   logic presc_roll; // Prescaler stage that drives the counter rolls over.
   logic overflow; // Timeout reached.
   logic [WDT_EV_W-1:0] ev_set; // Events this cycle.

   // Pin detectors come from outside the clock domain.
   wdt_sync3 #(
      .WIDTH(2)
   ) u_hv_sync (
      .clock(clock),
      .rst(rst),
      .async_in({test_high_voltage_interrupt_pin, test_high_voltage_rst_pin}),
      .sync_out(hv_sync)
   );
   assign hv_rst_pin = hv_sync[0];
   assign hv_irq_pin = hv_sync[1];

   // Configuration fields drive the watchdog inputs directly.
   assign cfg.watchdog_disable = config_q[WDT_CFG_DISABLE_BIT];
   assign cfg.timeout_select = config_q[WDT_CFG_TSEL_BIT];

   // The configuration bit, monitor mode and break state can each stop it.
   always_comb begin
      wd_disabled = cfg.watchdog_disable;
      // Monitor mode with high voltage on either pin.
      if (monitor_mode && (hv_rst_pin || hv_irq_pin)) begin
         wd_disabled = 1'b1;
      end
      // Break state with high voltage on the reset pin.
      if (break_state && hv_rst_pin) begin
         wd_disabled = 1'b1;
      end
   end

   // Any write to the service location counts, whatever the data.
   assign service_wr = bus_req.wr && (bus_req.addr == WDT_SERVICE_ADDR);

   // Sources that clear the whole prescaler.
   assign presc_clear_all = stop_mode
      || reset_vector_fetch
      || por_clear
      || internal_reset
      || wd_disabled;

   // The counter steps at the rollover of the selected prescaler stage.
   always_comb begin
      if (cfg.timeout_select) begin
         presc_roll = &presc_q;
      end else begin
         presc_roll = &presc_q[WDT_SHORT_PRESC_W-1:0];
      end
   end

   // Overflow fires at the last counter value once the upper prescaler stages
   // above the kept ones are full and the kept ones are zero. From a cleared
   // state this gives 2^18 - 2^4 or 2^13 - 2^4 cycles.
   always_comb begin
      overflow = 1'b0;
      if (!wd_disabled && !stop_mode && pulse_q == '0 && count_q == COUNT_MAX) begin
         if (presc_q[WDT_PRESC_KEEP-1:0] == '0) begin
            if (cfg.timeout_select) begin
               overflow = &presc_q[WDT_PRESC_W-1:WDT_PRESC_KEEP];
            end else begin
               overflow = &presc_q[WDT_SHORT_PRESC_W-1:WDT_PRESC_KEEP];
            end
         end
      end
   end

   // Power-on sequencer: wait out the settle time, then clear once.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         por_state_q <= WDT_POR_WAIT;
         por_cnt_q <= '0;
      end else begin
         unique case (por_state_q)
            WDT_POR_WAIT: begin
               // Count oscillator cycles since power up.
               if (por_cnt_q == POR_LAST) begin
                  por_state_q <= WDT_POR_CLEAR;
               end else begin
                  por_cnt_q <= por_cnt_q + POR_W'(1);
               end
            end
            WDT_POR_CLEAR: begin
               // The clear pulse lasts this one state.
               por_state_q <= WDT_POR_DONE;
            end
            WDT_POR_DONE: begin
               // Stay here until the next power-on reset.
               por_state_q <= WDT_POR_DONE;
            end
            default: begin
               // An illegal code recovers to the idle end state.
               por_state_q <= WDT_POR_DONE;
            end
         endcase
      end
   end
   assign por_clear = (por_state_q == WDT_POR_CLEAR);

   // Prescaler on the oscillator clock. A service write keeps stages 1 to 4,
   // which is why both timeouts fall 2^4 short of a power of two.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         presc_q <= '0;
      end else if (presc_clear_all) begin
         presc_q <= '0;
      end else if (service_wr) begin
         presc_q[WDT_PRESC_W-1:WDT_PRESC_KEEP] <= '0;
         presc_q[WDT_PRESC_KEEP-1:0] <= presc_q[WDT_PRESC_KEEP-1:0] + WDT_PRESC_KEEP'(1);
      end else begin
         // Wait mode does not stop this count.
         presc_q <= presc_q + WDT_PRESC_W'(1);
      end
   end

   // Watchdog counter; stop mode freezes it since its clock input is removed.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (internal_reset || wd_disabled || pulse_q != '0) begin
         count_q <= '0;
      end else if (service_wr) begin
         count_q <= '0;
      end else if (stop_mode) begin
         count_q <= count_q;
      end else if (presc_roll) begin
         count_q <= count_q + WDT_COUNT_W'(1);
      end
   end

   // Reset pin low time, started by an overflow.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pulse_q <= '0;
      end else if (overflow) begin
         pulse_q <= PULSE_LOAD;
      end else if (pulse_q != '0) begin
         pulse_q <= pulse_q - PULSE_ONE;
      end
   end

   // The request and pin drive last exactly the pulse time; the pin is
   // open drain, so the data is always low and the enable does the work.
   assign watchdog_reset_req = (pulse_q != '0);
   assign rst_pin_oe = (pulse_q != '0);
   assign rst_pin_out = 1'b0;

   // Configuration register; reserved bits stay zero.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config_q <= WDT_CONFIG_RESET;
      end else if (bus_req.wr && bus_req.addr == WDT_CONFIG_ADDR) begin
         config_q <= '0;
         config_q[WDT_CFG_DISABLE_BIT] <= bus_req.wdata[WDT_CFG_DISABLE_BIT];
         config_q[WDT_CFG_TSEL_BIT] <= bus_req.wdata[WDT_CFG_TSEL_BIT];
      end
   end

   // Reset cause flag: an overflow in the clearing cycle still wins.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cause_q <= '0;
      end else begin
         if (bus_req.wr && bus_req.addr == WDT_CAUSE_ADDR && bus_req.wdata[WDT_CAUSE_WD_BIT]) begin
            cause_q[WDT_CAUSE_WD_BIT] <= 1'b0;
         end
         if (overflow) begin
            cause_q[WDT_CAUSE_WD_BIT] <= 1'b1;
         end
      end
   end

   // Events that software may watch on the system event line.
   always_comb begin
      ev_set = '0;
      ev_set[WDT_EV_OVERFLOW_BIT] = overflow;
      ev_set[WDT_EV_SERVICE_BIT] = service_wr;
   end

   // Sticky status, cleared by writing ones; a new event beats the clear.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_q <= '0;
      end else if (bus_req.wr && bus_req.addr == WDT_STATUS_ADDR) begin
         status_q <= (status_q & ~bus_req.wdata[WDT_EV_W-1:0]) | ev_set;
      end else begin
         status_q <= status_q | ev_set;
      end
   end

   // Event mask; all events are gated off after reset.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_q <= WDT_MASK_RESET[WDT_EV_W-1:0];
      end else if (bus_req.wr && bus_req.addr == WDT_MASK_ADDR) begin
         mask_q <= bus_req.wdata[WDT_EV_W-1:0];
      end
   end

   // This line goes to the system unit, not to the processor interrupt
   // logic; the watchdog itself only ever acts through reset.
   assign event_irq = |(status_q & mask_q);

   // Read data registered one cycle after the strobe.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            WDT_SERVICE_ADDR: begin
               // The location overlaps the vector, so no watchdog state shows.
               rdata_q <= reset_vector_low;
            end
            WDT_CONFIG_ADDR: begin
               rdata_q <= config_q;
            end
            WDT_CAUSE_ADDR: begin
               rdata_q <= cause_q;
            end
            WDT_STATUS_ADDR: begin
               rdata_q <= {{(WDT_DATA_W-WDT_EV_W){1'b0}}, status_q};
            end
            WDT_MASK_ADDR: begin
               rdata_q <= {{(WDT_DATA_W-WDT_EV_W){1'b0}}, mask_q};
            end
            WDT_COUNT_ADDR: begin
               rdata_q <= {{(WDT_DATA_W-WDT_COUNT_W){1'b0}}, count_q};
            end
            default: begin
               // Unmapped addresses read a fixed value.
               rdata_q <= WDT_UNMAPPED_DATA;
            end
         endcase
      end else begin
         rdata_q <= '0;
      end
   end
   assign bus_rdata = rdata_q;

endmodule // wdt_watchdog

/* File: wdt_pkg.sv */
package wdt_pkg;

   // Register bus geometry.
   localparam int unsigned WDT_ADDR_W = 16;
   localparam int unsigned WDT_DATA_W = 8;

   // Register offsets. The service location overlaps the low reset-vector byte.
   localparam logic [15:0] WDT_SERVICE_ADDR = 16'hFFFF;
   localparam logic [15:0] WDT_CONFIG_ADDR = 16'hFE00;
   localparam logic [15:0] WDT_CAUSE_ADDR = 16'hFE01;
   localparam logic [15:0] WDT_STATUS_ADDR = 16'hFE02;
   localparam logic [15:0] WDT_MASK_ADDR = 16'hFE03;
   localparam logic [15:0] WDT_COUNT_ADDR = 16'hFE04;

   // Configuration register fields and reset value.
   localparam int unsigned WDT_CFG_DISABLE_BIT = 0;
   localparam int unsigned WDT_CFG_TSEL_BIT = 1;
   localparam logic [7:0] WDT_CONFIG_RESET = 8'h00;

   // Reset cause register field.
   localparam int unsigned WDT_CAUSE_WD_BIT = 0;

   // Event status and mask fields.
   localparam int unsigned WDT_EV_OVERFLOW_BIT = 0;
   localparam int unsigned WDT_EV_SERVICE_BIT = 1;
   localparam int unsigned WDT_EV_W = 2;
   localparam logic [7:0] WDT_MASK_RESET = 8'h00;

   // Counter geometry.
   localparam int unsigned WDT_PRESC_W = 12;
   localparam int unsigned WDT_COUNT_W = 6;
   // Prescaler stages kept by a service write (stages 1 to 4).
   localparam int unsigned WDT_PRESC_KEEP = 4;
   // Prescaler width that sets the short period (2^13 - 2^4 cycles).
   localparam int unsigned WDT_SHORT_PRESC_W = 7;

   // Reset pin low time in clock cycles.
   localparam int unsigned WDT_RST_PULSE_CYCLES = 32;
   // Power-on settle delay before the prescaler is cleared.
   localparam int unsigned WDT_POR_CYCLES = 4096;

   // Unmapped reads return this value.
   localparam logic [7:0] WDT_UNMAPPED_DATA = 8'h00;

   // One request on the register port.
   typedef struct packed {
      logic [WDT_ADDR_W-1:0] addr;
      logic [WDT_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } wdt_bus_req_t;

   // Configuration fields as seen by the counting logic.
   typedef struct packed {
      logic timeout_select;
      logic watchdog_disable;
   } wdt_cfg_t;

   // Power-on sequencer states.
   typedef enum logic [1:0] {
      WDT_POR_WAIT = 2'b00,
      WDT_POR_CLEAR = 2'b01,
      WDT_POR_DONE = 2'b10
   } wdt_por_state_t;

endpackage

/* File: wdt_sync3.sv */
`timescale 1ns/1ns

// Three-stage synchroniser per bit; a new level is accepted once the
// second and third stages agree, which filters a one-cycle glitch.
module wdt_sync3 #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Asynchronous inputs and their filtered, synchronous copies.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Refuse a width that leaves nothing to synchronise.
   if (WIDTH < 1) begin : g_chk
      $error("wdt_sync3: WIDTH must be at least 1.");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q; // First stage, read only by the second.
      logic s2_q; // Second stage.
      logic s3_q; // Third stage.

      // Shift chain; only constants are loaded under reset.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
         end else begin
            s1_q <= async_in[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
         end
      end

      // Accept the level only when the last two stages agree.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            sync_out[i] <= 1'b0;
         end else if (s2_q == s3_q) begin
            sync_out[i] <= s3_q;
         end
      end
   end

endmodule // wdt_sync3

/* File: wdt_monitor.sv */
`timescale 1ns/1ns

// Port-level checker for the watchdog; pulse length is counted in helper logic.
module wdt_monitor
   import wdt_pkg::*;
#(
   parameter int unsigned RST_PULSE_CYCLES = WDT_RST_PULSE_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Register port.
   input wire wdt_bus_req_t bus_req,
   input wire logic [WDT_DATA_W-1:0] bus_rdata,
   input wire logic [WDT_DATA_W-1:0] reset_vector_low,
   // System controls.
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic stop_mode,
   input wire logic internal_reset,
   input wire logic reset_vector_fetch,
   input wire logic test_high_voltage_rst_pin,
   input wire logic test_high_voltage_interrupt_pin,
   // Reset outputs.
   input wire logic watchdog_reset_req,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe
);
   // Cycles the pin has been driven in the current pulse.
   logic [7:0] hi_cnt_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Counts while the pin is driven, so the length is judged when it falls.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hi_cnt_q <= 8'h00;
      end else if (rst_pin_oe) begin
         hi_cnt_q <= hi_cnt_q + 8'h01;
      end else begin
         hi_cnt_q <= 8'h00;
      end
   end

   a_req_pin_pair: assert property (watchdog_reset_req == rst_pin_oe)
      else $error("reset request and pin drive differ");
   a_pin_drives_low: assert property (rst_pin_oe |-> !rst_pin_out)
      else $error("reset pin driven high");
   a_pulse_length: assert property ($fell(rst_pin_oe) |-> hi_cnt_q == RST_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   a_pulse_bound: assert property (rst_pin_oe |-> hi_cnt_q < RST_PULSE_CYCLES)
      else $error("reset pulse too long");
   a_service_read: assert property ($past(bus_req.rd) && $past(bus_req.addr) == WDT_SERVICE_ADDR
      |-> bus_rdata == $past(reset_vector_low))
      else $error("service read not the vector byte");
   a_service_holds: assert property (bus_req.wr && bus_req.addr == WDT_SERVICE_ADDR
      |-> ##2 (!$rose(watchdog_reset_req)) [*4])
      else $error("reset right after service");
   a_stop_holds: assert property (stop_mode ##1 stop_mode |-> !$rose(watchdog_reset_req))
      else $error("reset while stopped");
   a_monitor_hv_off: assert property ((monitor_mode && (test_high_voltage_rst_pin
      || test_high_voltage_interrupt_pin)) [*6] |-> !$rose(watchdog_reset_req))
      else $error("reset in monitor mode with high voltage");
   a_break_hv_off: assert property ((break_state && test_high_voltage_rst_pin) [*6]
      |-> !$rose(watchdog_reset_req))
      else $error("reset in break state with high voltage");
   a_fetch_clears: assert property (reset_vector_fetch |-> ##2 !$rose(watchdog_reset_req))
      else $error("reset right after vector fetch");
   a_intrst_clears: assert property (internal_reset |-> ##2 !$rose(watchdog_reset_req))
      else $error("reset right after internal reset");

   // Main scenarios.
   c_overflow: cover property ($rose(watchdog_reset_req));
   c_service: cover property (bus_req.wr && bus_req.addr == WDT_SERVICE_ADDR);
   c_stop: cover property (stop_mode ##1 stop_mode);
   c_monitor: cover property (monitor_mode && test_high_voltage_interrupt_pin);
endmodule // wdt_monitor

bind wdt_watchdog wdt_monitor #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) i_mon (
   .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .reset_vector_low(reset_vector_low), .monitor_mode(monitor_mode),
   .break_state(break_state), .stop_mode(stop_mode), .internal_reset(internal_reset),
   .reset_vector_fetch(reset_vector_fetch),
   .test_high_voltage_rst_pin(test_high_voltage_rst_pin),
   .test_high_voltage_interrupt_pin(test_high_voltage_interrupt_pin),
   .watchdog_reset_req(watchdog_reset_req), .rst_pin_out(rst_pin_out),
   .rst_pin_oe(rst_pin_oe)
);

/* File: test_watchdog_timer_block.sv */
`timescale 1ns/1ns

// Drives the watchdog through its register port and system controls.
module test_watchdog_timer_block
   import wdt_pkg::*;
;
   // Design signals.
   logic clock, rst, mon, brk, stop, irst, fetch, hvr, hvi, req, pin_out, pin_oe, irq;
   wdt_bus_req_t bus_req;
   logic [7:0] bus_rdata, vec_low, rdat;
   // Bookkeeping; hits counts cycles with the reset request high.
   int num_errors, checks, n, hits, hits0;
   // Case table: {expect reset, timeout select, disable, monitor, break, stop, hv rst, hv int}.
   logic [7:0] cases [8] = '{8'h80, 8'h20, 8'h40, 8'h11, 8'h12, 8'h0A, 8'h89, 8'h04};
   logic [15:0] idle_regs [5] = '{WDT_CONFIG_ADDR, WDT_CAUSE_ADDR, WDT_STATUS_ADDR,
      WDT_MASK_ADDR, 16'h1234};

   // A short power-on delay keeps the run brief.
   wdt_watchdog #(.POR_CYCLES(16), .RST_PULSE_CYCLES(32)) i_dut (
      .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .reset_vector_low(vec_low), .monitor_mode(mon), .break_state(brk),
      .stop_mode(stop), .internal_reset(irst), .reset_vector_fetch(fetch),
      .test_high_voltage_rst_pin(hvr), .test_high_voltage_interrupt_pin(hvi),
      .watchdog_reset_req(req), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe),
      .event_irq(irq)
   );

   // Free-running 250 MHz clock.
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Counts reset-request cycles so long waits can be judged afterwards.
   always @(posedge clock) begin
      if (req === 1'b1) hits++;
   end

   task automatic fail(input string msg);
      $display("[FAIL] %0t %s", $time, msg);
      num_errors++;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) fail("data mismatch");
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) fail("flag mismatch");
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask

   // One-cycle write; strobe drops at the edge that takes it.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask

   // One-cycle read; data stands only in the cycle after the strobe.
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 rdat = bus_rdata;
      chk8(rdat, exp);
   endtask

   task automatic pulse_fetch();
      @(posedge clock);
      fetch <= 1'b1;
      @(posedge clock);
      fetch <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Sets one case, clears the prescaler, then waits past the short timeout.
   task automatic run_case(input logic [7:0] c);
      wr(WDT_CONFIG_ADDR, {6'h00, c[6:5]});
      @(posedge clock);
      {mon, brk, stop, hvr, hvi} <= c[4:0];
      cyc(8);
      pulse_fetch();
      n = 0;
      while (n < 8400 && req !== 1'b1) begin
         @(posedge clock);
         #1 n++;
      end
      chk1(n < 8400, c[7]);
      if (c[7]) begin
         chk1(n >= 8174 && n <= 8179, 1'b1);
         n = 0;
         while (req === 1'b1 && n < 64) begin
            chk1(pin_out, 1'b0);
            chk1(pin_oe, 1'b1);
            @(posedge clock);
            #1 n++;
         end
         if (n == 64) begin
            fail("reset pulse never ended");
            report_and_stop();
         end
         chk8(n[7:0], 8'h20);
         rchk(WDT_CAUSE_ADDR, 8'h01);
         rchk(WDT_STATUS_ADDR, 8'h01);
         wr(WDT_MASK_ADDR, 8'h01);
         @(posedge clock);
         #1 chk1(irq, 1'b1);
         wr(WDT_STATUS_ADDR, 8'h01);
         wr(WDT_CAUSE_ADDR, 8'h01);
         @(posedge clock);
         #1 chk1(irq, 1'b0);
         rchk(WDT_CAUSE_ADDR, 8'h00);
         wr(WDT_MASK_ADDR, 8'h00);
      end
      @(posedge clock);
      {mon, brk, stop, hvr, hvi} <= 5'h00;
      cyc(8);
   endtask

   // Main sequence.
   initial begin
      bus_req = '0;
      vec_low = 8'hA5;
      {mon, brk, stop, irst, fetch, hvr, hvi} = 7'h00;
      rst = 1'b1;
      num_errors = 0;
      checks = 0;
      hits = 0;
      cyc(6);
      rst <= 1'b0;
      // Reset values, with an unmapped address last.
      foreach (idle_regs[i]) rchk(idle_regs[i], 8'h00);
      rchk(WDT_SERVICE_ADDR, 8'hA5);
      @(posedge clock);
      vec_low <= 8'h3C;
      rchk(WDT_SERVICE_ADDR, 8'h3C);
      foreach (cases[i]) run_case(cases[i]);
      // Counter readback, then internal reset and service both clear it.
      pulse_fetch();
      cyc(1000);
      rchk(WDT_COUNT_ADDR, 8'h07);
      @(posedge clock);
      irst <= 1'b1;
      @(posedge clock);
      irst <= 1'b0;
      rchk(WDT_COUNT_ADDR, 8'h00);
      // Software services straight after the reset, as it should.
      wr(WDT_SERVICE_ADDR, 8'hFF);
      cyc(1000);
      wr(WDT_SERVICE_ADDR, 8'h5A);
      rchk(WDT_COUNT_ADDR, 8'h00);
      hits0 = hits;
      repeat (2) begin
         cyc(6000);
         wr(WDT_SERVICE_ADDR, 8'h00);
      end
      chk1(hits == hits0, 1'b1);
      rchk(WDT_STATUS_ADDR, 8'h02);
      report_and_stop();
   end
endmodule // test_watchdog_timer_block
